// ### scpt_pkg.sv
// Constants and types for the serial configuration port and gain-curve test logic
// Operation
// - Enable line low for whole transfer; data ignored while it is high.
// - Serial input sampled on each serial clock rising edge while enabled.
// - Shifted word committed to addressed register on every 24th rising edge.
// - Partial trailing frame at enable rise is discarded, no register written.
// - Back-to-back frames allowed; bit counter wraps after each 24th edge and clears while enable is high.
// - Frame is 8-bit address followed by 16-bit data.
// - With readback enabled, addressed register content is driven on serial output.
// - Readback enable stays writable in readback mode; clearing it restores writes.
// - Serial output driven only while readback enable is set.
// - Internal start bit makes device create start pulses in internal mode.
// - After curve completes, next internal start waits programmed ADC cycles.
// - Manual start gives one start pulse in ramp and internal modes.
// - Manual start in ramp mode also gives a gain return pulse.
// - Attenuator sweeps first, LNA second, unless order swap bit set.
// - Attenuator disable bit keeps attenuation block disabled.
// - Fixed attenuation bit holds attenuation at profile field value N.
// - Mode select bit picks continuous-wave, switching LNA and disabling filter.
// - ADC power-down bit powers converter down completely.
// - Exactly one of time-gain and continuous-wave modes is active.
// - After reset the path is in time-gain mode, mode select cleared.
package scpt_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int         FRAME_BITS = 24;
    localparam int         ADDR_BITS  = 8;
    localparam int         DATA_BITS  = 16;
    localparam logic [4:0] CNT_LAST   = 5'h17;
    localparam logic [4:0] CNT_ADDR   = 5'h07;
    localparam logic [4:0] CNT_DATA   = 5'h08;

    // ----------------------------------------------------------------
    // Register addresses, storage slots and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] A_RDBK = 8'h00;
    localparam logic [7:0] A_PDN  = 8'h01;
    localparam logic [7:0] A_INT  = 8'hb5;
    localparam logic [7:0] A_ORD  = 8'hb6;
    localparam logic [7:0] A_WAIT = 8'hb7;
    localparam logic [7:0] A_PROF = 8'hb8;
    localparam logic [7:0] A_MODE = 8'hc0;
    localparam int         NSLOT  = 7;
    localparam logic [2:0] S_RDBK = 3'h0;
    localparam logic [2:0] S_PDN  = 3'h1;
    localparam logic [2:0] S_INT  = 3'h2;
    localparam logic [2:0] S_ORD  = 3'h3;
    localparam logic [2:0] S_WAIT = 3'h4;
    localparam logic [2:0] S_PROF = 3'h5;
    localparam logic [2:0] S_MODE = 3'h6;
    localparam int         B_RDBK_EN    = 1;
    localparam int         B_PDN        = 0;
    localparam int         B_INT_START  = 14;
    localparam int         B_MANUAL     = 13;
    localparam int         B_GMODE_LSB  = 0;
    localparam int         B_ORDER_SWAP = 6;
    localparam int         B_ATTEN_DIS  = 7;
    localparam int         B_FIX_EN     = 15;
    localparam int         B_ATTEN_N    = 0;
    localparam int         ATTEN_N_W    = 7;
    localparam int         B_CW_SEL     = 0;
    localparam logic [15:0] REG_RESET   = 16'h0000;

    // ----------------------------------------------------------------
    // Synchroniser lanes
    // ----------------------------------------------------------------
    localparam int SY_W     = 6;
    localparam int SY_SCLK  = 0;
    localparam int SY_SEN_N = 1;
    localparam int SY_SDI   = 2;
    localparam int SY_ADC   = 3;
    localparam int SY_START = 4;
    localparam int SY_RET   = 5;

    typedef enum logic [1:0] {
        GM_EXT  = 2'b00,
        GM_UPDN = 2'b01,
        GM_INT  = 2'b10
    } scpt_gmode_e;

    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_SWEEP = 2'b01,
        ENG_WAIT  = 2'b10
    } scpt_eng_e;

endpackage

// ### scpt_sync.sv
// Two-stage synchroniser with edge detection for asynchronous inputs
module scpt_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } scpt_sync_s;

    scpt_sync_s st;
    scpt_sync_s next_st;

    // First stage feeds only the second stage
    always_comb
    begin
        next_st.meta = async_in;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st <= '0;
        else
            st <= next_st;
    end

    assign sync_out = st.sync;
    assign rise     = st.sync & ~st.prev;
    assign fall     = ~st.sync & st.prev;
endmodule

// ### scpt_top.sv
// Serial configuration port with gain-curve test modes and mode selection
module scpt_top #(
    parameter logic [15:0] CURVE_LEN = 16'h0100
) (
    input  wire logic                           ref_clk,
    input  wire logic                           srst,
    input  wire logic                           serial_clk,
    input  wire logic                           serial_enable_n,
    input  wire logic                           serial_in,
    output logic                                serial_out,
    output logic                                serial_out_oe,
    input  wire logic                           adc_clk,
    input  wire logic                           gain_start_pin,
    input  wire logic                           gain_return_pin,
    output logic                                gain_start,
    output logic                                gain_return,
    output logic                                atten_sweep,
    output logic                                lna_sweep,
    output logic                                atten_enable,
    output logic                                atten_fixed,
    output logic [scpt_pkg::ATTEN_N_W-1:0]      atten_fixed_code,
    output logic                                cw_mode,
    output logic                                tgc_mode,
    output logic                                lna_cw_config,
    output logic                                lpf_disable,
    output logic                                adc_full_powerdown
);
    import scpt_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [4:0]                  bit_cnt;
        logic [FRAME_BITS-2:0]       shift;
        logic [DATA_BITS-1:0]        rd_shift;
        logic                        sdo;
        logic                        sdo_oe;
        logic [NSLOT-1:0][15:0]      regs;
        logic                        manual;
        scpt_eng_e                   eng;
        logic [15:0]                 eng_cnt;
        logic                        start_p;
        logic                        return_p;
        logic                        atten_sw;
        logic                        lna_sw;
        logic                        atten_en;
        logic                        fixed;
        logic [ATTEN_N_W-1:0]        fixed_code;
        logic                        cw;
        logic                        tgc;
        logic                        pdn;
    } scpt_state_s;

    scpt_state_s st;
    scpt_state_s next_st;

    logic [SY_W-1:0] s_lvl;
    logic [SY_W-1:0] s_rise;
    logic [SY_W-1:0] s_fall;

    scpt_sync #(
        .W (SY_W)
    ) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in ({gain_return_pin, gain_start_pin, adc_clk, serial_in, serial_enable_n, serial_clk}),
        .sync_out (s_lvl),
        .rise     (s_rise),
        .fall     (s_fall)
    );

    logic                  en_n;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  sdi;
    logic                  adc_tick;
    logic                  rd_en;
    logic [FRAME_BITS-1:0] word;
    logic [3:0]            wr_hit;
    logic [3:0]            rd_hit;
    logic                  wr_en;
    logic                  trig;
    logic                  int_p;
    logic                  first_half;
    scpt_gmode_e           gmode;

    assign en_n      = s_lvl[SY_SEN_N];
    assign sclk_rise = s_rise[SY_SCLK];
    assign sclk_fall = s_fall[SY_SCLK];
    assign sdi       = s_lvl[SY_SDI];
    assign adc_tick  = s_rise[SY_ADC];
    assign rd_en     = st.regs[S_RDBK][B_RDBK_EN];
    assign gmode     = scpt_gmode_e'(st.regs[S_INT][B_GMODE_LSB+1:B_GMODE_LSB]);

    // Address decode: bit 3 flags a mapped address, bits 2:0 give the slot
    function automatic logic [3:0] slot_of(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        unique case (a)
            A_RDBK:  r = {1'b1, S_RDBK};
            A_PDN:   r = {1'b1, S_PDN};
            A_INT:   r = {1'b1, S_INT};
            A_ORD:   r = {1'b1, S_ORD};
            A_WAIT:  r = {1'b1, S_WAIT};
            A_PROF:  r = {1'b1, S_PROF};
            A_MODE:  r = {1'b1, S_MODE};
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        word    = {st.shift, sdi};
        wr_hit  = slot_of(word[FRAME_BITS-1 -: ADDR_BITS]);
        rd_hit  = slot_of({st.shift[ADDR_BITS-2:0], sdi});
        wr_en   = 1'b0;
        next_st.manual = 1'b0;
        if (en_n)
        begin
            next_st.bit_cnt = 5'h00;
        end
        else if (sclk_rise)
        begin
            next_st.shift = word[FRAME_BITS-2:0];
            if (st.bit_cnt == CNT_LAST)
            begin
                next_st.bit_cnt = 5'h00;
                // In readback mode only the readback enable stays writable
                wr_en = wr_hit[3] && (!rd_en || wr_hit[2:0] == S_RDBK);
            end
            else
            begin
                next_st.bit_cnt = st.bit_cnt + 5'h01;
            end
            if (st.bit_cnt == CNT_ADDR && rd_en)
                next_st.rd_shift = rd_hit[3] ? st.regs[rd_hit[2:0]] : 16'h0000;
        end
        // Bits leave on falling edges so they settle before the next rise
        if (!en_n && sclk_fall && rd_en && st.bit_cnt >= CNT_DATA)
        begin
            next_st.sdo      = st.rd_shift[DATA_BITS-1];
            next_st.rd_shift = {st.rd_shift[DATA_BITS-2:0], 1'b0};
        end
        if (wr_en)
        begin
            next_st.regs[wr_hit[2:0]] = word[DATA_BITS-1:0];
            if (wr_hit[2:0] == S_INT)
            begin
                // Manual start is self-clearing and reads back as zero
                next_st.regs[S_INT][B_MANUAL] = 1'b0;
                next_st.manual = word[B_MANUAL];
            end
        end
        next_st.sdo_oe = rd_en;

        // ------------------------------------------------------------
        // Gain-curve engine, counted in ADC clock cycles
        // ------------------------------------------------------------
        int_p = 1'b0;
        // An idle engine starts at once; a finished curve waits the programmed ticks
        if (gmode == GM_INT && st.regs[S_INT][B_INT_START]
            && (st.eng == ENG_IDLE || (st.eng == ENG_WAIT && st.eng_cnt >= st.regs[S_WAIT])))
            int_p = 1'b1;
        trig = s_rise[SY_START] || int_p
            || (st.manual && (gmode == GM_UPDN || gmode == GM_INT));
        unique case (st.eng)
            ENG_IDLE:
            begin
                if (trig)
                begin
                    next_st.eng     = ENG_SWEEP;
                    next_st.eng_cnt = 16'h0000;
                end
            end
            ENG_SWEEP:
            begin
                if (adc_tick)
                begin
                    if (st.eng_cnt == CURVE_LEN - 16'h0001)
                    begin
                        next_st.eng     = ENG_WAIT;
                        next_st.eng_cnt = 16'h0000;
                    end
                    else
                    begin
                        next_st.eng_cnt = st.eng_cnt + 16'h0001;
                    end
                end
            end
            ENG_WAIT:
            begin
                if (trig)
                begin
                    next_st.eng     = ENG_SWEEP;
                    next_st.eng_cnt = 16'h0000;
                end
                else if (adc_tick && st.eng_cnt != 16'hffff)
                begin
                    next_st.eng_cnt = st.eng_cnt + 16'h0001;
                end
            end
            default:
            begin
                next_st.eng     = ENG_IDLE;
                next_st.eng_cnt = 16'h0000;
            end
        endcase
        next_st.start_p  = trig;
        next_st.return_p = s_rise[SY_RET] || (st.manual && gmode == GM_UPDN);

        // Stage order: attenuator first unless swapped
        first_half = st.eng_cnt < {1'b0, CURVE_LEN[15:1]};
        next_st.atten_sw = st.tgc && st.eng == ENG_SWEEP && st.atten_en && !st.fixed
            && (first_half != st.regs[S_ORD][B_ORDER_SWAP]);
        next_st.lna_sw   = st.tgc && st.eng == ENG_SWEEP
            && (first_half == st.regs[S_ORD][B_ORDER_SWAP]);
        next_st.atten_en   = !st.regs[S_ORD][B_ATTEN_DIS];
        next_st.fixed      = st.regs[S_PROF][B_FIX_EN];
        next_st.fixed_code = st.regs[S_PROF][B_ATTEN_N +: ATTEN_N_W];
        next_st.cw  = st.regs[S_MODE][B_CW_SEL];
        next_st.tgc = !st.regs[S_MODE][B_CW_SEL];
        next_st.pdn = st.regs[S_PDN][B_PDN];
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st          <= '0;
            st.regs     <= {NSLOT{REG_RESET}};
            st.eng      <= ENG_IDLE;
            st.atten_en <= 1'b1;
            st.tgc      <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign serial_out         = st.sdo;
    assign serial_out_oe      = st.sdo_oe;
    assign gain_start         = st.start_p;
    assign gain_return        = st.return_p;
    assign atten_sweep        = st.atten_sw;
    assign lna_sweep          = st.lna_sw;
    assign atten_enable       = st.atten_en;
    assign atten_fixed        = st.fixed;
    assign atten_fixed_code   = st.fixed_code;
    assign cw_mode            = st.cw;
    assign tgc_mode           = st.tgc;
    assign lna_cw_config      = st.cw;
    assign lpf_disable        = st.cw;
    assign adc_full_powerdown = st.pdn;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_IDLE_IGNORES: assert property (en_n |=> st.bit_cnt == 5'h00 && $stable(st.shift))
        else $error("shift moved while enable high");
    AST_SAMPLE_RISE: assert property (!en_n && sclk_rise |=> st.shift[0] == $past(sdi))
        else $error("serial input not sampled on rising edge");
    AST_COMMIT_24TH: assert property (wr_en |-> st.bit_cnt == CNT_LAST && sclk_rise && !en_n)
        else $error("register write off the frame boundary");
    AST_WRITE_LANDS: assert property (wr_en && wr_hit[2:0] == S_WAIT
        |=> st.regs[S_WAIT] == $past(word[DATA_BITS-1:0]))
        else $error("committed word not stored");
    AST_PARTIAL_DROP: assert property ($rose(en_n) |=> st.bit_cnt == 5'h00 ##1 st.bit_cnt == 5'h00)
        else $error("partial frame count survived enable rise");
    AST_COUNT_STEP: assert property (!en_n && sclk_rise && st.bit_cnt != CNT_LAST
        |=> st.bit_cnt == $past(st.bit_cnt) + 5'h01)
        else $error("bit counter did not advance");
    AST_READ_BLOCKS: assert property (wr_en && rd_en |-> wr_hit[2:0] == S_RDBK)
        else $error("write accepted during readback");
    AST_OE_FOLLOWS: assert property (serial_out_oe == $past(rd_en))
        else $error("serial output enable wrong");
    AST_SDO_FALL: assert property (!$stable(serial_out) |-> $past(sclk_fall))
        else $error("serial output changed away from falling edge");
    AST_INT_START: assert property (int_p |=> gain_start ##1 st.eng == ENG_SWEEP)
        else $error("internal start pulse missing");
    AST_MANUAL_RET: assert property (st.manual && gmode == GM_UPDN |=> gain_start && gain_return)
        else $error("manual start pulses missing");
    AST_SWAP_ORDER: assert property (atten_sweep |-> $past(first_half != st.regs[S_ORD][B_ORDER_SWAP]))
        else $error("attenuator swept in wrong half");
    AST_FIXED_HOLD: assert property ($past(atten_fixed) || !$past(atten_enable) |-> !atten_sweep)
        else $error("attenuator swept while fixed or disabled");
    AST_MODE_EXCL: assert property (tgc_mode != cw_mode && lpf_disable == cw_mode)
        else $error("time-gain and continuous-wave both active");
    AST_RESET_TGC: assert property (disable iff (1'b0) srst |=> tgc_mode && !cw_mode)
        else $error("reset did not select time-gain mode");

    COV_WRITE: cover property (wr_en);
    COV_READ: cover property (rd_en && sclk_fall && st.bit_cnt == CNT_LAST);
    COV_INT_START: cover property (int_p);
    COV_CW: cover property ($rose(cw_mode));
endmodule

// ### scpt_ctrl_model.sv
// Behavioural serial controller that frames words onto the configuration port
module scpt_ctrl_model (
    output logic      serial_clk,
    output logic      serial_enable_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 32;

    initial
    begin
        serial_clk      = 1'b0;
        serial_enable_n = 1'b1;
        serial_in       = 1'b0;
    end

    // Words are left aligned. Between frames the clock stands low and data rests at its pull-down level.
    task automatic xfer(input logic [47:0] w, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        serial_enable_n = 1'b0;
        #HALF;
        for (int i = 0; i < nbits; i++)
        begin
            serial_in = w[47-i];
            #HALF;
            if (i % 24 >= 8)
                rd[23 - i % 24] = serial_out;
            serial_clk = 1'b1;
            #HALF;
            serial_clk = 1'b0;
        end
        #HALF;
        serial_enable_n = 1'b1;
        serial_in       = 1'b0;
        #HALF;
    endtask
endmodule

// ### scpt_top_tb.sv
// Self-checking bench for the serial configuration port and gain-curve test logic
module scpt_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import scpt_pkg::*;

    logic       ref_clk, srst, adc_clk, gain_start_pin, gain_return_pin;
    logic       serial_clk, serial_enable_n, serial_in, serial_out, serial_out_oe;
    logic       gain_start, gain_return, atten_sweep, lna_sweep, atten_enable, atten_fixed;
    logic [6:0] atten_fixed_code;
    logic       cw_mode, tgc_mode, lna_cw_config, lpf_disable, adc_full_powerdown;
    logic [1:0] first = 2'h3;
    int         err_count, check_count, starts, returns, ticks, gap, last_start;

    scpt_top #(.CURVE_LEN(16'h0008)) dut (.ref_clk, .srst, .serial_clk, .serial_enable_n, .serial_in,
        .serial_out, .serial_out_oe, .adc_clk, .gain_start_pin, .gain_return_pin, .gain_start,
        .gain_return, .atten_sweep, .lna_sweep, .atten_enable, .atten_fixed, .atten_fixed_code,
        .cw_mode, .tgc_mode, .lna_cw_config, .lpf_disable, .adc_full_powerdown);
    // A released output line has no pull, so the model sees it flipped
    scpt_ctrl_model ctrl (.serial_clk, .serial_enable_n, .serial_in,
        .serial_out(serial_out_oe ? serial_out : ~serial_out));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        adc_clk = 1'b0;
        forever #20 adc_clk = ~adc_clk;
    end
    always @(posedge adc_clk) ticks++;

    // ----------------------------------------------------------------
    // Pulse monitor: counts starts and returns, notes which stage sweeps first
    // ----------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        if (gain_start === 1'b1)
        begin
            starts++;
            gap        = ticks - last_start;
            last_start = ticks;
            first      = 2'h0;
        end
        else if (first == 2'h0 && atten_sweep === 1'b1)
            first = 2'h1;
        else if (first == 2'h0 && lna_sweep === 1'b1)
            first = 2'h2;
        if (gain_return === 1'b1)
            returns++;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [15:0] r);
        ctrl.xfer({a, d, 24'h000000}, 24, r);
        repeat (10) @(posedge ref_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #300000;
        err_count++;
        complete_run;
    end

    initial
    begin
        logic [15:0] v, n, rd;
        srst            = 1'b1;
        gain_start_pin  = 1'b0;
        gain_return_pin = 1'b0;
        void'($urandom(32'hfcd1));
        repeat (10) @(posedge ref_clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge ref_clk);
        check("reset", {cw_mode, lna_cw_config, lpf_disable, adc_full_powerdown, serial_out_oe,
            atten_fixed, tgc_mode, atten_enable}, 16'h0003);
        $display("test reset done");
        for (int k = 1; k >= 0; k--)
        begin
            wr(A_MODE, 16'(k), rd);
            check("mode", {cw_mode, tgc_mode, lna_cw_config, lpf_disable}, k ? 16'h000b : 16'h0004);
        end
        repeat (4)
        begin
            v = 16'($urandom);
            n = 16'($urandom);
            wr(A_PROF, v, rd);
            wr(A_ORD, n, rd);
            wr(A_PDN, n, rd);
            check("fixed", {atten_fixed, atten_fixed_code}, {v[15], v[6:0]});
            check("atten_en", atten_enable, !n[7]);
            check("pdn", adc_full_powerdown, n[0]);
        end
        $display("test fields done");
        ctrl.xfer({A_MODE, 16'h0001, A_PDN, 16'h0001}, 48, rd);
        repeat (10) @(posedge ref_clk);
        check("two frames", {cw_mode, adc_full_powerdown}, 16'h0003);
        ctrl.xfer({A_MODE, 16'h0000, A_PDN, 16'h0000}, 47, rd);
        repeat (10) @(posedge ref_clk);
        check("partial", {cw_mode, adc_full_powerdown}, 16'h0001);
        $display("test framing done");
        v = 16'($urandom);
        wr(A_PROF, v, rd);
        wr(A_RDBK, 16'h0002, rd);
        check("oe on", serial_out_oe, 16'h0001);
        wr(A_PROF, 16'h0000, rd);
        check("readback", rd, v);
        wr(A_PROF, 16'h0000, rd);
        check("readback", rd, v);
        wr(8'h02, 16'hffff, rd);
        check("unmapped", rd, 16'h0000);
        wr(A_MODE, 16'h0001, rd);
        wr(A_RDBK, 16'h0000, rd);
        check("oe off", {serial_out_oe, cw_mode}, 16'h0000);
        $display("test readback done");
        wr(A_PROF, 16'h0000, rd);
        wr(A_ORD, 16'h0000, rd);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
                wr(A_ORD, 16'h0040, rd);
            starts  = 0;
            returns = 0;
            wr(A_INT, k ? 16'h2002 : 16'h2001, rd);
            repeat (100) @(posedge ref_clk);
            check("manual", 16'({starts[1:0], returns[1:0]}), k ? 16'h0004 : 16'h0005);
            check("order", first, k == 2 ? 16'h0002 : 16'h0001);
        end
        $display("test manual done");
        wr(A_ORD, 16'h0000, rd);
        v = 16'($urandom_range(20, 2));
        wr(A_WAIT, v, rd);
        starts = 0;
        wr(A_INT, 16'h4002, rd);
        repeat ((8 + 32'(v)) * 40) @(posedge ref_clk);
        check("int starts", 16'(starts >= 3), 16'h0001);
        check("gap", 16'(gap >= 8 + v && gap <= 10 + v), 16'h0001);
        wr(A_INT, 16'h0000, rd);
        repeat (400) @(posedge ref_clk);
        starts  = 0;
        returns = 0;
        @(posedge ref_clk) #1 gain_start_pin = 1'b1;
        repeat (10) @(posedge ref_clk) #1;
        gain_start_pin  = 1'b0;
        gain_return_pin = 1'b1;
        repeat (10) @(posedge ref_clk) #1;
        gain_return_pin = 1'b0;
        repeat (400) @(posedge ref_clk);
        check("pins", 16'({starts[1:0], returns[1:0]}), 16'h0005);
        $display("test gain engine done");
        complete_run;
    end
endmodule
